// ---- hw/regfile_pkg.sv ----
// constants, address map and types for the banked data register file
//
// Contract
// - general storage is never cleared by reset
// - F60h to FFFh decode as special registers
// - general storage fills banks from bank 0 up
// - every storage byte works as any operand
// - storage reachable directly and through pointers
// - indirect access uses pointer pair at operand port
// - special registers are static cells in data space
// - empty special addresses read zero, ignore writes
// - indirect ports hold nothing, redirect to pointer
// - 12-bit address, 16 banks, 4-bit selector
// - pointer pairs hold full 12-bit addresses
// - access bank joins bank 0 and bank 15 segments
package regfile_pkg;

  // address and data widths
  localparam int unsigned ADDR_W = 12;          // full data address width
  localparam int unsigned DATA_W = 8;           // byte wide data path
  localparam int unsigned BANK_W = 4;           // implemented bank selector bits
  localparam int unsigned N_PTR  = 3;           // number of pointer sets

  // first special register address; everything below is general storage
  localparam logic [11:0] SFR_BASE      = 12'hF60;
  // access bank split: low offsets map to bank 0, the rest to bank 15
  localparam logic [7:0]  ACCESS_SPLIT  = 8'h60;
  localparam logic [3:0]  ACCESS_HI_BANK = 4'hF;
  localparam logic [3:0]  ACCESS_LO_BANK = 4'h0;

  // core special registers held by this block
  localparam logic [11:0] ALU_FLAGS                = 12'hFD8;
  localparam logic [11:0] POINTER2_LOW             = 12'hFD9;
  localparam logic [11:0] POINTER2_HIGH            = 12'hFDA;
  localparam logic [11:0] INDIRECT2_PLUS_ACCUM     = 12'hFDB;
  localparam logic [11:0] INDIRECT2_PRE_INCREMENT  = 12'hFDC;
  localparam logic [11:0] INDIRECT2_POST_DECREMENT = 12'hFDD;
  localparam logic [11:0] INDIRECT2_POST_INCREMENT = 12'hFDE;
  localparam logic [11:0] INDIRECT2_OPERAND        = 12'hFDF;
  localparam logic [11:0] BANK_SELECTOR            = 12'hFE0;
  localparam logic [11:0] POINTER1_LOW             = 12'hFE1;
  localparam logic [11:0] POINTER1_HIGH            = 12'hFE2;
  localparam logic [11:0] INDIRECT1_PLUS_ACCUM     = 12'hFE3;
  localparam logic [11:0] INDIRECT1_PRE_INCREMENT  = 12'hFE4;
  localparam logic [11:0] INDIRECT1_POST_DECREMENT = 12'hFE5;
  localparam logic [11:0] INDIRECT1_POST_INCREMENT = 12'hFE6;
  localparam logic [11:0] INDIRECT1_OPERAND        = 12'hFE7;
  localparam logic [11:0] WORKING_ACCUMULATOR      = 12'hFE8;
  localparam logic [11:0] POINTER0_LOW             = 12'hFE9;
  localparam logic [11:0] POINTER0_HIGH            = 12'hFEA;
  localparam logic [11:0] INDIRECT0_PLUS_ACCUM     = 12'hFEB;
  localparam logic [11:0] INDIRECT0_PRE_INCREMENT  = 12'hFEC;
  localparam logic [11:0] INDIRECT0_POST_DECREMENT = 12'hFED;
  localparam logic [11:0] INDIRECT0_POST_INCREMENT = 12'hFEE;
  localparam logic [11:0] INDIRECT0_OPERAND        = 12'hFEF;

  // per pointer set tables, index 0 is set 0
  localparam logic [2:0][11:0] PTR_LOW_ADDR  = {POINTER2_LOW, POINTER1_LOW, POINTER0_LOW};
  localparam logic [2:0][11:0] PTR_HIGH_ADDR = {POINTER2_HIGH, POINTER1_HIGH, POINTER0_HIGH};
  localparam logic [2:0][11:0] IND_OP_ADDR   =
    {INDIRECT2_OPERAND, INDIRECT1_OPERAND, INDIRECT0_OPERAND};
  localparam logic [2:0][11:0] IND_PINC_ADDR =
    {INDIRECT2_POST_INCREMENT, INDIRECT1_POST_INCREMENT, INDIRECT0_POST_INCREMENT};
  localparam logic [2:0][11:0] IND_PDEC_ADDR =
    {INDIRECT2_POST_DECREMENT, INDIRECT1_POST_DECREMENT, INDIRECT0_POST_DECREMENT};
  localparam logic [2:0][11:0] IND_PRE_ADDR  =
    {INDIRECT2_PRE_INCREMENT, INDIRECT1_PRE_INCREMENT, INDIRECT0_PRE_INCREMENT};
  localparam logic [2:0][11:0] IND_PLUS_ADDR =
    {INDIRECT2_PLUS_ACCUM, INDIRECT1_PLUS_ACCUM, INDIRECT0_PLUS_ACCUM};

  // values after reset of the core registers
  localparam logic [11:0] PTR_RESET   = 12'h000;
  localparam logic [3:0]  BANK_RESET  = 4'h0;
  localparam logic [7:0]  ACC_RESET   = 8'h00;
  localparam logic [7:0]  FLAGS_RESET = 8'h00;
  localparam logic [7:0]  RDATA_RESET = 8'h00;

  // how the datapath forms its address
  typedef enum logic [1:0] {
    ADDR_FULL   = 2'b00,  // 12-bit address given whole
    ADDR_ACCESS = 2'b01,  // 8-bit offset into the access bank
    ADDR_BANKED = 2'b10   // 8-bit offset into the selected bank
  } addr_kind_t;

  // all clocked control state of the block
  typedef struct packed {
    logic [2:0][11:0] ptr;    // pointer pairs
    logic [3:0]       bank;   // bank selector, low nibble only
    logic [7:0]       acc;    // working accumulator
    logic [7:0]       flags;  // alu flags
    logic [7:0]       rdata;  // registered read data
  } state_t;

endpackage

// ---- hw/banked_data_register_file.sv ----
// banked data memory with core special registers and indirect pointer ports
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps

module banked_data_register_file (
  input  wire logic        clk,          // core clock, 200 MHz
  input  wire logic        rstn,         // asynchronous reset, active low
  input  wire logic        clk_en,       // freezes all state while low
  input  wire logic [11:0] addr,         // address or 8-bit offset in the low byte
  input  wire logic [1:0]  addr_kind,    // how addr is to be read
  input  wire logic [7:0]  wdata,        // write data
  input  wire logic        wr,           // write strobe
  input  wire logic        rd,           // read strobe
  input  wire logic        flags_we,     // alu writes its flags this cycle
  input  wire logic [7:0]  flags_wdata,  // new flags from the alu
  output logic      [7:0]  rdata,        // read data, valid the cycle after rd
  output logic      [7:0]  working_accumulator, // accumulator to the alu
  output logic      [7:0]  alu_flags,    // flags to the alu
  output logic      [7:0]  bank_selector,// bank selector, upper nibble zero
  output logic      [11:0] pointer0,     // pointer set 0
  output logic      [11:0] pointer1,     // pointer set 1
  output logic      [11:0] pointer2      // pointer set 2
);

  // number of general storage bytes, everything below the special area
  localparam int unsigned GPR_BYTES = int'(regfile_pkg::SFR_BASE);

  // registered control state and its next value
  regfile_pkg::state_t s_q;   // current state
  regfile_pkg::state_t s_d;   // next state

  // general storage; kept outside the state record because it has no reset
  logic [7:0] mem_q [0:GPR_BYTES-1];

  // access in progress this cycle
  logic        access;        // either strobe
  logic [11:0] eff_addr;      // address after banking
  logic [11:0] phys_addr;     // address after pointer redirection
  logic        ind_any;       // the effective address is an indirect port

  // per pointer set decode results
  logic [2:0]        ind_hit;      // set k owns the addressed indirect port
  logic [2:0][11:0]  ind_tgt;      // location that set k points at
  logic [2:0]        step_en;      // set k moves its pointer
  logic [2:0][11:0]  step_val;     // pointer value after the move

  // memory side
  logic        mem_hit;       // physical address is general storage
  logic        mem_we;        // write into general storage
  logic [7:0]  mem_rd;        // storage byte at the physical address

  // either strobe counts as an access; the master never raises both
  assign access = rd | wr;

  // effective address from the addressing kind
  always_comb begin
    eff_addr = addr;
    unique case (regfile_pkg::addr_kind_t'(addr_kind))
      regfile_pkg::ADDR_FULL: begin
        // whole 12-bit address, as used by two-word moves
        eff_addr = addr;
      end
      regfile_pkg::ADDR_ACCESS: begin
        // low offsets land in bank 0, high offsets in the top of bank 15
        if (addr[7:0] < regfile_pkg::ACCESS_SPLIT) begin
          eff_addr = {regfile_pkg::ACCESS_LO_BANK, addr[7:0]};
        end else begin
          eff_addr = {regfile_pkg::ACCESS_HI_BANK, addr[7:0]};
        end
      end
      regfile_pkg::ADDR_BANKED: begin
        // only the four implemented selector bits form the bank
        eff_addr = {s_q.bank, addr[7:0]};
      end
      default: begin
        // the unused code falls back to a whole address
        eff_addr = addr;
      end
    endcase
  end

  // one decoder per pointer set for its five indirect ports
  for (genvar k = 0; k < regfile_pkg::N_PTR; k++) begin : g_ptr
    logic        is_op;     // plain operand port
    logic        is_pinc;   // post-increment port
    logic        is_pdec;   // post-decrement port
    logic        is_pre;    // pre-increment port
    logic        is_plus;   // plus-accumulator port
    logic [11:0] ptr;       // this set's pointer
    logic [11:0] acc_sx;    // accumulator sign extended to an address

    assign ptr     = s_q.ptr[k];
    assign acc_sx  = {{4{s_q.acc[7]}}, s_q.acc};
    assign is_op   = eff_addr == regfile_pkg::IND_OP_ADDR[k];
    assign is_pinc = eff_addr == regfile_pkg::IND_PINC_ADDR[k];
    assign is_pdec = eff_addr == regfile_pkg::IND_PDEC_ADDR[k];
    assign is_pre  = eff_addr == regfile_pkg::IND_PRE_ADDR[k];
    assign is_plus = eff_addr == regfile_pkg::IND_PLUS_ADDR[k];

    // any of the five ports routes the access through this pointer
    assign ind_hit[k] = is_op | is_pinc | is_pdec | is_pre | is_plus;

    // target: pre-increment looks one ahead, plus adds the signed accumulator
    always_comb begin
      if (is_pre) begin
        ind_tgt[k] = ptr + 12'h001;
      end else if (is_plus) begin
        ind_tgt[k] = ptr + acc_sx;
      end else begin
        ind_tgt[k] = ptr;
      end
    end

    // pointer movement around the access; wraps within 12 bits
    assign step_en[k]  = access & (is_pinc | is_pdec | is_pre);
    assign step_val[k] = is_pdec ? ptr - 12'h001 : ptr + 12'h001;
  end

  // redirect an indirect port to the location its pointer holds
  always_comb begin
    ind_any   = |ind_hit;
    phys_addr = eff_addr;
    for (int k = 0; k < regfile_pkg::N_PTR; k++) begin
      if (ind_hit[k]) begin
        phys_addr = ind_tgt[k];
      end
    end
  end

  // everything below the special area is storage, bank 0 upward
  assign mem_hit = phys_addr < regfile_pkg::SFR_BASE;
  assign mem_we  = clk_en & wr & mem_hit;
  // the index is only used when the address is in range
  assign mem_rd  = mem_hit ? mem_q[phys_addr] : 8'h00;

  // storage write port; deliberately no reset so contents survive it
  always_ff @(posedge clk) begin
    if (mem_we) begin
      mem_q[phys_addr] <= wdata;
    end
  end

  // next value of the control state
  always_comb begin
    logic [7:0] rd_val;     // value that a read at phys_addr returns
    rd_val = 8'h00;
    s_d    = s_q;

    // read mux; empty special addresses and indirect ports read zero
    if (mem_hit) begin
      rd_val = mem_rd;
    end else begin
      unique case (phys_addr)
        regfile_pkg::WORKING_ACCUMULATOR: begin
          rd_val = s_q.acc;
        end
        regfile_pkg::ALU_FLAGS: begin
          rd_val = s_q.flags;
        end
        regfile_pkg::BANK_SELECTOR: begin
          // upper nibble is not built and reads zero
          rd_val = {4'h0, s_q.bank};
        end
        default: begin
          rd_val = 8'h00;
        end
      endcase
      // pointer halves; high half shows the four upper address bits
      for (int k = 0; k < regfile_pkg::N_PTR; k++) begin
        if (phys_addr == regfile_pkg::PTR_LOW_ADDR[k]) begin
          rd_val = s_q.ptr[k][7:0];
        end
        if (phys_addr == regfile_pkg::PTR_HIGH_ADDR[k]) begin
          rd_val = {4'h0, s_q.ptr[k][11:8]};
        end
      end
    end

    // read data is captured and held until the next read
    if (rd) begin
      s_d.rdata = rd_val;
    end

    // alu flag update from the datapath
    if (flags_we) begin
      s_d.flags = flags_wdata;
    end

    // pointer movement happens on reads and writes alike
    for (int k = 0; k < regfile_pkg::N_PTR; k++) begin
      if (step_en[k]) begin
        s_d.ptr[k] = step_val[k];
      end
    end

    // register writes; a write to a pointer half wins over its movement
    if (wr && !mem_hit) begin
      unique case (phys_addr)
        regfile_pkg::WORKING_ACCUMULATOR: begin
          s_d.acc = wdata;
        end
        regfile_pkg::ALU_FLAGS: begin
          // an explicit store beats the alu's own update
          s_d.flags = wdata;
        end
        regfile_pkg::BANK_SELECTOR: begin
          s_d.bank = wdata[3:0];
        end
        default: begin
          // empty special address or indirect port: nothing is kept
          s_d.bank = s_q.bank;
        end
      endcase
      for (int k = 0; k < regfile_pkg::N_PTR; k++) begin
        if (phys_addr == regfile_pkg::PTR_LOW_ADDR[k]) begin
          s_d.ptr[k][7:0] = wdata;
        end
        if (phys_addr == regfile_pkg::PTR_HIGH_ADDR[k]) begin
          s_d.ptr[k][11:8] = wdata[3:0];
        end
      end
    end

    // a nested indirect access lands on a port with no storage: reads zero,
    // writes vanish; ind_any only documents that the redirect happened once
    if (ind_any && !mem_hit && rd) begin
      s_d.rdata = rd_val;
    end
  end

  // control state register; clk_en low freezes everything
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_q.ptr   <= {3{regfile_pkg::PTR_RESET}};
      s_q.bank  <= regfile_pkg::BANK_RESET;
      s_q.acc   <= regfile_pkg::ACC_RESET;
      s_q.flags <= regfile_pkg::FLAGS_RESET;
      s_q.rdata <= regfile_pkg::RDATA_RESET;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  // outputs straight from flip-flops
  assign rdata               = s_q.rdata;
  assign working_accumulator = s_q.acc;
  assign alu_flags           = s_q.flags;
  assign bank_selector       = {4'h0, s_q.bank};
  assign pointer0            = s_q.ptr[0];
  assign pointer1            = s_q.ptr[1];
  assign pointer2            = s_q.ptr[2];

endmodule

// ---- tb/alu_flag_source.sv ----
// alu side model that sends flag updates toward the register file
`timescale 1ns/1ps
module alu_flag_source (
  input  wire logic       clk,         // core clock
  input  wire logic       go,          // asks for one flag update
  input  wire logic [7:0] val,         // flags to send
  output logic            flags_we,    // update strobe
  output logic      [7:0] flags_wdata  // flags, junk outside the strobe
);
  initial flags_we = 1'b0;
  initial flags_wdata = 8'h5A;
  // junk moves every cycle off the strobe except from 1Dh or 9Dh, which repeat, so a stale value passes only for those two
  always @(posedge clk) begin
    flags_we <= go;
    flags_wdata <= go ? val : ~flags_wdata + 8'h3B;
  end
endmodule

// ---- tb/regfile_monitor.sv ----
// port assertions for the banked data register file
`timescale 1ns/1ps
module regfile_monitor (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        clk_en,
  input wire logic [11:0] addr,
  input wire logic [1:0]  addr_kind,
  input wire logic [7:0]  wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic        flags_we,
  input wire logic [7:0]  flags_wdata,
  input wire logic [7:0]  rdata,
  input wire logic [7:0]  working_accumulator,
  input wire logic [7:0]  alu_flags,
  input wire logic [7:0]  bank_selector,
  input wire logic [11:0] pointer0,
  input wire logic [11:0] pointer1,
  input wire logic [11:0] pointer2
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // taken requests that carry a whole 12-bit address
  wire fr = clk_en && rd && addr_kind == 2'h0;
  wire fw = clk_en && wr && addr_kind == 2'h0;
  bank_hi_zero_a: assert property (bank_selector[7:4] == 4'h0)
    else $error("bank selector upper nibble set");
  bank_write_a: assert property (fw && addr == 12'hFE0
    |=> bank_selector == ($past(wdata) & 8'h0F)) else $error("bank selector write lost");
  empty_read_a: assert property (fr && (addr >= 12'hF60 && addr < 12'hFD8 || addr > 12'hFEF)
    |=> rdata == 8'h00) else $error("empty special address read nonzero");
  acc_write_a: assert property (fw && addr == 12'hFE8
    |=> working_accumulator == $past(wdata)) else $error("accumulator write lost");
  post_inc_a: assert property (fr && addr == 12'hFEE
    |=> pointer0 == $past(pointer0) + 12'h001) else $error("post increment wrong");
  post_dec_a: assert property (fr && addr == 12'hFE5
    |=> pointer1 == $past(pointer1) - 12'h001) else $error("post decrement wrong");
  pre_inc_a: assert property ((fr || fw) && addr == 12'hFDC
    |=> pointer2 == $past(pointer2) + 12'h001) else $error("pre increment wrong");
  plus_keeps_a: assert property ((fr || fw) && addr == 12'hFEB |=> $stable(pointer0))
    else $error("offset port moved the pointer");
  quiet_hold_a: assert property (!(clk_en && (wr || rd))
    |=> $stable(pointer0) && $stable(working_accumulator) && $stable(bank_selector))
    else $error("register changed without a request");
  rdata_hold_a: assert property (!(clk_en && rd) |=> $stable(rdata))
    else $error("read data changed without a read");
  flags_upd_a: assert property (clk_en && flags_we && !wr
    |=> alu_flags == $past(flags_wdata)) else $error("flag update lost");
endmodule
bind banked_data_register_file regfile_monitor mon (
  .clk(clk), .rstn(rstn), .clk_en(clk_en), .addr(addr), .addr_kind(addr_kind),
  .wdata(wdata), .wr(wr), .rd(rd), .flags_we(flags_we), .flags_wdata(flags_wdata),
  .rdata(rdata), .working_accumulator(working_accumulator), .alu_flags(alu_flags),
  .bank_selector(bank_selector), .pointer0(pointer0), .pointer1(pointer1),
  .pointer2(pointer2));

// ---- tb/tb_banked_data_register_file.sv ----
// self-checking bench for the banked data register file
`timescale 1ns/1ps
module tb_banked_data_register_file;
  logic        clk, rstn, clk_en, wr, rd, go, flags_we, rd_seen;
  logic [11:0] addr, a, p;
  logic [1:0]  addr_kind;
  logic [7:0]  wdata, fval, flags_wdata, rdata, acc, flg, bsel, d;
  logic [11:0] ptr [3];         // pointer outputs
  logic [7:0]  exp_q [$];       // expected read data, oldest first
  logic [7:0]  mem [int];       // model of general storage
  int          n_fail = 0;
  int          compares = 0;
  int          seed = 57266;
  localparam logic [11:0] EMPTY [4] = '{12'hF60, 12'hF9C, 12'hFD7, 12'hFFF};
  banked_data_register_file dut (.clk(clk), .rstn(rstn), .clk_en(clk_en), .addr(addr),
    .addr_kind(addr_kind), .wdata(wdata), .wr(wr), .rd(rd), .flags_we(flags_we),
    .flags_wdata(flags_wdata), .rdata(rdata), .working_accumulator(acc), .alu_flags(flg),
    .bank_selector(bsel), .pointer0(ptr[0]), .pointer1(ptr[1]), .pointer2(ptr[2]));
  alu_flag_source alu (.clk(clk), .go(go), .val(fval), .flags_we(flags_we),
    .flags_wdata(flags_wdata));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic cmp(string n, logic [11:0] e, logic [11:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  // one bus cycle; calls in a row give back-to-back strobes
  task automatic op(bit w, logic [11:0] ad, logic [1:0] k, logic [7:0] dt);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    addr <= ad;
    addr_kind <= k;
    wdata <= dt;
  endtask
  task automatic wrb(logic [11:0] ad, logic [7:0] dt, logic [1:0] k = 2'h0);
    op(1'b1, ad, k, dt);
  endtask
  // read data is random on the write-data lines, which a read must ignore
  task automatic rdb(logic [11:0] ad, logic [7:0] e, logic [1:0] k = 2'h0);
    op(1'b0, ad, k, 8'($random(seed)));
    exp_q.push_back(e);
  endtask
  task automatic idle;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  // result watcher: data of a taken read stand in the following cycle
  initial rd_seen = 1'b0;
  always @(posedge clk) rd_seen <= rstn && clk_en && rd;
  always @(negedge clk) if (rd_seen) cmp("rdata", {4'h0, exp_q.pop_front()}, {4'h0, rdata});
  task automatic end_of_test;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    #20000;
    n_fail++;
    end_of_test;
  end
  initial begin
    {rstn, wr, rd, go, fval, addr, addr_kind, wdata} = '0;
    clk_en = 1'b1;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    rdb(12'hFE8, 8'h00);
    rdb(12'hFE0, 8'h00);
    // storage at both ends of the range, then 38 random addresses below F60h
    for (int i = 0; i < 40; i++) begin
      a = (i < 2) ? (i ? 12'hF5F : 12'h000) : 12'($unsigned($random(seed)) % 32'hF60);
      d = 8'($random(seed));
      mem[a] = d;
      wrb(a, d);
    end
    for (int j = 0; j < 4; j++) wrb(EMPTY[j], 8'h00);
    for (int j = 0; j < 4; j++) rdb(EMPTY[j], 8'h00);
    foreach (mem[k]) rdb(12'(k), mem[k]);
    // banked and access-bank forms of the address
    wrb(12'hFE0, 8'hAB);
    wrb(12'h034, 8'h77, 2'h2);
    wrb(12'h010, 8'h66, 2'h1);
    wrb(12'h0E8, 8'h85, 2'h1);
    rdb(12'hFE0, 8'h0B);
    rdb(12'hB34, 8'h77);
    rdb(12'h010, 8'h66);
    rdb(12'h0E8, 8'h85, 2'h1);
    rdb(12'h070, 8'h00, 2'h1);
    // every port of each pointer set; accumulator 85h is a negative offset
    for (int n = 0; n < 3; n++) begin
      p = 12'h300 + 12'(n) * 12'h111;
      wrb(regfile_pkg::PTR_LOW_ADDR[n], p[7:0]);
      wrb(regfile_pkg::PTR_HIGH_ADDR[n], {4'hF, p[11:8]});
      wrb(regfile_pkg::IND_OP_ADDR[n], 8'h11);
      rdb(regfile_pkg::IND_PINC_ADDR[n], 8'h11);
      wrb(regfile_pkg::IND_PINC_ADDR[n], 8'h22);
      wrb(regfile_pkg::IND_PRE_ADDR[n], 8'h33);
      rdb(regfile_pkg::IND_PDEC_ADDR[n], 8'h33);
      wrb(regfile_pkg::IND_PLUS_ADDR[n], 8'h44);
      rdb(p + 12'h001, 8'h22);
      rdb(p + 12'h003, 8'h33);
      rdb(p - 12'h079, 8'h44);
      rdb(regfile_pkg::PTR_HIGH_ADDR[n], {4'h0, p[11:8]});
      idle;
      @(negedge clk);
      cmp("pointer", p + 12'h002, ptr[n]);
    end
    cmp("accumulator", 12'h085, {4'h0, acc});
    // flag update from the alu side
    @(posedge clk);
    go <= 1'b1;
    fval <= 8'h3C;
    @(posedge clk);
    go <= 1'b0;
    rdb(12'hFD8, 8'h3C);
    // a write with the enable low is dropped
    // the enable drops only after the first write has been taken
    wrb(12'h005, 8'h99);
    idle;
    clk_en <= 1'b0;
    wrb(12'h005, 8'hEE);
    idle;
    clk_en <= 1'b1;
    rdb(12'h005, 8'h99);
    idle;
    idle;
    // a reset in mid-run leaves storage alone
    rstn <= 1'b0;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    rdb(12'h005, 8'h99);
    rdb(12'hFE8, 8'h00);
    idle;
    repeat (2) @(posedge clk);
    end_of_test;
  end
endmodule
